// File: include/rspc_pkg.sv
package rspc_pkg;

    // Register count and index width
    localparam int NUM_REGS = 17;
    localparam int IDX_W    = 5;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] OFS_ANALOG_IF  = 8'h07;
    localparam logic [7:0] OFS_DIV_TOP    = 8'h08;
    localparam logic [7:0] OFS_DIV_UMID   = 8'h09;
    localparam logic [7:0] OFS_DIV_LMID   = 8'h0A;
    localparam logic [7:0] OFS_DIV_LOW    = 8'h0B;
    localparam logic [7:0] OFS_CH_STEP    = 8'h0C;
    localparam logic [7:0] OFS_DIGITAL_IF = 8'h0D;
    localparam logic [7:0] OFS_TRIM_HIGH  = 8'h0E;
    localparam logic [7:0] OFS_TRIM_LOW   = 8'h0F;
    localparam logic [7:0] OFS_SLOT_EIGHT = 8'h10;
    localparam logic [7:0] OFS_SLOT_SEVEN = 8'h11;
    localparam logic [7:0] OFS_SLOT_SIX   = 8'h12;
    localparam logic [7:0] OFS_SLOT_FIVE  = 8'h13;
    localparam logic [7:0] OFS_SLOT_FOUR  = 8'h14;
    localparam logic [7:0] OFS_SLOT_SEL   = 8'h18;
    localparam logic [7:0] OFS_SETUP_REF  = 8'h9E;
    localparam logic [7:0] OFS_SETUP_SPL  = 8'h9F;

    // Reset values, reserved bits included
    localparam logic [7:0] RST_ANALOG_IF  = 8'hA3;
    localparam logic [7:0] RST_DIV_TOP    = 8'h0C;
    localparam logic [7:0] RST_DIV_UMID   = 8'h84;
    localparam logic [7:0] RST_DIV_LMID   = 8'hEC;
    localparam logic [7:0] RST_DIV_LOW    = 8'h51;
    localparam logic [7:0] RST_CH_STEP    = 8'hFC;
    localparam logic [7:0] RST_DIGITAL_IF = 8'hA3;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_SLOT_EIGHT = 8'h03;
    localparam logic [7:0] RST_SLOT_SEVEN = 8'h0E;
    localparam logic [7:0] RST_SLOT_SIX   = 8'h1A;
    localparam logic [7:0] RST_SLOT_FIVE  = 8'h25;
    localparam logic [7:0] RST_SLOT_FOUR  = 8'h35;
    localparam logic [7:0] RST_SLOT_SEL   = 8'h07;
    localparam logic [7:0] RST_SETUP_REF  = 8'h5B;
    localparam logic [7:0] RST_SETUP_SPL  = 8'h20;

    // Writable bits; the rest read back their reset value
    localparam logic [7:0] MSK_FULL      = 8'hFF;
    localparam logic [7:0] MSK_NIBBLE    = 8'h0F;
    localparam logic [7:0] MSK_LEVEL     = 8'h7F;
    localparam logic [7:0] MSK_SLOT_SEL  = 8'h07;
    localparam logic [7:0] MSK_SETUP_REF = 8'h86;
    localparam logic [7:0] MSK_SETUP_SPL = 8'h80;

    localparam logic [NUM_REGS-1:0][7:0] REG_OFS = {
        OFS_SETUP_SPL, OFS_SETUP_REF, OFS_SLOT_SEL, OFS_SLOT_FOUR, OFS_SLOT_FIVE,
        OFS_SLOT_SIX, OFS_SLOT_SEVEN, OFS_SLOT_EIGHT, OFS_TRIM_LOW, OFS_TRIM_HIGH,
        OFS_DIGITAL_IF, OFS_CH_STEP, OFS_DIV_LOW, OFS_DIV_LMID, OFS_DIV_UMID,
        OFS_DIV_TOP, OFS_ANALOG_IF};
    localparam logic [NUM_REGS-1:0][7:0] REG_RST = {
        RST_SETUP_SPL, RST_SETUP_REF, RST_SLOT_SEL, RST_SLOT_FOUR, RST_SLOT_FIVE,
        RST_SLOT_SIX, RST_SLOT_SEVEN, RST_SLOT_EIGHT, RST_ZERO, RST_ZERO,
        RST_DIGITAL_IF, RST_CH_STEP, RST_DIV_LOW, RST_DIV_LMID, RST_DIV_UMID,
        RST_DIV_TOP, RST_ANALOG_IF};
    localparam logic [NUM_REGS-1:0][7:0] REG_MSK = {
        MSK_SETUP_SPL, MSK_SETUP_REF, MSK_SLOT_SEL, MSK_LEVEL, MSK_LEVEL,
        MSK_LEVEL, MSK_LEVEL, MSK_LEVEL, MSK_FULL, MSK_NIBBLE,
        MSK_FULL, MSK_FULL, MSK_FULL, MSK_FULL, MSK_FULL,
        MSK_FULL, MSK_FULL};

    // Field positions
    localparam int SPLIT_BIT  = 7;
    localparam int REFERENCE_HALVER_BIT = 7;
    localparam int VCO_L_BIT  = 2;
    localparam int VCO_H_BIT  = 1;

    // Split times in picoseconds, selected by the split bit
    localparam int TSPLIT_SHORT_PS = 1750;
    localparam int TSPLIT_LONG_PS  = 3470;

    // Band select codes and their divide factors
    localparam logic [2:0] BAND_HIGH    = 3'h1;
    localparam logic [2:0] BAND_MIDDLE  = 3'h3;
    localparam logic [2:0] BAND_LOW     = 3'h4;
    localparam logic [2:0] BAND_VLOW    = 3'h5;
    localparam logic [5:0] FACTOR_HIGH  = 6'h06;
    localparam logic [5:0] FACTOR_MID   = 6'h0C;
    localparam logic [5:0] FACTOR_LOW   = 6'h10;
    localparam logic [5:0] FACTOR_VLOW  = 6'h20;
    localparam logic [5:0] FACTOR_NONE  = 6'h00;

    // Settings handed to the analog and digital consumers
    typedef struct packed {
        logic             split_time_select;
        logic             reference_halver;
        logic             low_oscillator_enable;
        logic             high_oscillator_enable;
        logic [2:0]       pump_current_code;
        logic [25:0]      pll_divider_word;
        logic [2:0]       band_divide_select;
        logic [7:0]       channel_step_value;
        logic [7:0]       analog_if_value;
        logic [7:0]       digital_if_value;
        logic [11:0]      carrier_trim_value;
        logic [4:0][6:0]  power_levels;
        logic [2:0]       final_power_slot_index;
    } rspc_synth_cfg_type;

    // Address decode result
    typedef struct packed {
        logic             hit;
        logic [IDX_W-1:0] idx;
    } rspc_decode_type;

endpackage

// File: rtl/rspc_regs.sv
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Split-time select bit, reset zero
// (RULE2) Reference halver bit, reset zero
// (RULE3) Divider word assembled from four registers
// (RULE4) Pump current code in top register
// (RULE5) Band select picks out-of-loop divide factor
// (RULE6) Channel step value, reset 0xFC
// (RULE7) Separate analog and digital IF settings
// (RULE8) Twelve-bit signed carrier trim, reset zero
// (RULE9) Power slots eight to four, seven bits
// (RULE10) Final power slot index, reset 111
// (RULE11) Software writes reserved bits with reset values
// (RULE12) Read-write fields read back last write
module rspc_regs #(
    parameter int ADDR_WIDTH = 10
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_WIDTH-1:0]     paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output rspc_pkg::rspc_synth_cfg_type   synth_cfg,
    output logic      [5:0]                band_divide_factor
);

    // Highest index 0x9F needs byte address 0x27C
    if (ADDR_WIDTH < 10)
    begin : g_addr_too_narrow
        $error("ADDR_WIDTH must be at least 10");
    end

    // Byte address wider than the bus data word is not served
    if (ADDR_WIDTH > 32)
    begin : g_addr_too_wide
        $error("ADDR_WIDTH must be at most 32");
    end

    // Storage index must reach every register
    if ((1 << rspc_pkg::IDX_W) < rspc_pkg::NUM_REGS)
    begin : g_idx_too_narrow
        $error("IDX_W too small for NUM_REGS");
    end

    // Unpacked so that each register has its own driving process
    logic [7:0]                         reg_ff [rspc_pkg::NUM_REGS];
    logic [31:0]                        prdata_ff;
    logic                               pready_ff;
    logic                               pslverr_ff;
    logic [5:0]                         factor_ff;

    // Decode of the current address and qualifiers of the transfer
    rspc_pkg::rspc_decode_type          dec;
    logic                               acc_first;
    logic                               wr_en;
    logic [7:0]                         nxt_rdata;

    // Word index match; bits above the index must be zero
    function automatic logic is_at(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] ofs);
        logic hit;
        hit = addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(ofs);
        return hit;
    endfunction

    // Decode chain; a miss, misaligned or unmapped, leaves hit low
    function automatic rspc_pkg::rspc_decode_type find_reg(input logic [ADDR_WIDTH-1:0] addr);
        rspc_pkg::rspc_decode_type res;
        res = '0;
        // Index order matches the reset and mask tables
        if (addr[1:0] != 2'h0)
        begin
            res.hit = 1'b0;
            res.idx = 5'h00;
        end
        else if (is_at(addr, rspc_pkg::OFS_ANALOG_IF))
        begin
            res.hit = 1'b1;
            res.idx = 5'h00;
        end
        else if (is_at(addr, rspc_pkg::OFS_DIV_TOP))
        begin
            res.hit = 1'b1;
            res.idx = 5'h01;
        end
        else if (is_at(addr, rspc_pkg::OFS_DIV_UMID))
        begin
            res.hit = 1'b1;
            res.idx = 5'h02;
        end
        else if (is_at(addr, rspc_pkg::OFS_DIV_LMID))
        begin
            res.hit = 1'b1;
            res.idx = 5'h03;
        end
        else if (is_at(addr, rspc_pkg::OFS_DIV_LOW))
        begin
            res.hit = 1'b1;
            res.idx = 5'h04;
        end
        else if (is_at(addr, rspc_pkg::OFS_CH_STEP))
        begin
            res.hit = 1'b1;
            res.idx = 5'h05;
        end
        else if (is_at(addr, rspc_pkg::OFS_DIGITAL_IF))
        begin
            res.hit = 1'b1;
            res.idx = 5'h06;
        end
        else if (is_at(addr, rspc_pkg::OFS_TRIM_HIGH))
        begin
            res.hit = 1'b1;
            res.idx = 5'h07;
        end
        else if (is_at(addr, rspc_pkg::OFS_TRIM_LOW))
        begin
            res.hit = 1'b1;
            res.idx = 5'h08;
        end
        else if (is_at(addr, rspc_pkg::OFS_SLOT_EIGHT))
        begin
            res.hit = 1'b1;
            res.idx = 5'h09;
        end
        else if (is_at(addr, rspc_pkg::OFS_SLOT_SEVEN))
        begin
            res.hit = 1'b1;
            res.idx = 5'h0A;
        end
        else if (is_at(addr, rspc_pkg::OFS_SLOT_SIX))
        begin
            res.hit = 1'b1;
            res.idx = 5'h0B;
        end
        else if (is_at(addr, rspc_pkg::OFS_SLOT_FIVE))
        begin
            res.hit = 1'b1;
            res.idx = 5'h0C;
        end
        else if (is_at(addr, rspc_pkg::OFS_SLOT_FOUR))
        begin
            res.hit = 1'b1;
            res.idx = 5'h0D;
        end
        else if (is_at(addr, rspc_pkg::OFS_SLOT_SEL))
        begin
            res.hit = 1'b1;
            res.idx = 5'h0E;
        end
        else if (is_at(addr, rspc_pkg::OFS_SETUP_REF))
        begin
            res.hit = 1'b1;
            res.idx = 5'h0F;
        end
        else if (is_at(addr, rspc_pkg::OFS_SETUP_SPL))
        begin
            res.hit = 1'b1;
            res.idx = 5'h10;
        end
        return res;
    endfunction

    // Reserved bits of a register, fixed at their reset value
    function automatic logic [7:0] fixed_bits(input logic [rspc_pkg::IDX_W-1:0] idx);
        logic [7:0] val;
        val = rspc_pkg::REG_RST[idx] & ~rspc_pkg::REG_MSK[idx];
        return val;
    endfunction

    // Readback merges stored bits with constant reserved bits
    function automatic logic [7:0] read_reg(input rspc_pkg::rspc_decode_type d, input logic [7:0] r);
        logic [7:0] val;
        val = 8'h00;
        if (d.hit)
        begin
            val = r | fixed_bits(d.idx);
        end
        return val;
    endfunction

    // Decode once; readback and write strobe share it
    assign dec       = find_reg(paddr);
    assign nxt_rdata = read_reg(dec, reg_ff[dec.idx]); // RULE12

    // First access cycle, answer not yet given
    assign acc_first = psel && penable && !pready_ff;
    // Write lands only at the edge where pready is seen high
    assign wr_en     = psel && penable && pready_ff && pwrite && dec.hit && pstrb[0];

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_ff <= 1'b0;
        else
            pready_ff <= acc_first;
    end

    // Error rides with the answer; a miss never reaches storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_ff <= 1'b0;
        else
            pslverr_ff <= acc_first && !dec.hit;
    end

    // Read data stands in the answer cycle only, zero elsewhere
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (acc_first && !pwrite)
            prdata_ff <= {24'h00_0000, nxt_rdata}; // RULE12
        else
            prdata_ff <= 32'h0000_0000;
    end

    // Storage holds writable bits only; reserved bits are constants
    generate
        for (genvar g = 0; g < rspc_pkg::NUM_REGS; g++)
        begin : g_reg
            // Write select for this register alone
            logic sel;
            assign sel = wr_en && dec.idx == rspc_pkg::IDX_W'(g);

            // Reserved bits are never stored, so a stray write cannot flip them
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    reg_ff[g] <= rspc_pkg::REG_RST[g] & rspc_pkg::REG_MSK[g]; // RULE1 RULE2 RULE4 RULE10
                else if (sel)
                    reg_ff[g] <= pwdata[7:0] & rspc_pkg::REG_MSK[g]; // RULE12 RULE11
            end
        end
    endgenerate

    // Out-of-loop divide factor; undefined codes give zero
    function automatic logic [5:0] band_factor(input logic [2:0] code);
        logic [5:0] fac;
        case (code)
            rspc_pkg::BAND_HIGH:   fac = rspc_pkg::FACTOR_HIGH;
            rspc_pkg::BAND_MIDDLE: fac = rspc_pkg::FACTOR_MID;
            rspc_pkg::BAND_LOW:    fac = rspc_pkg::FACTOR_LOW;
            rspc_pkg::BAND_VLOW:   fac = rspc_pkg::FACTOR_VLOW;
            default:               fac = rspc_pkg::FACTOR_NONE;
        endcase
        return fac;
    endfunction

    // Divide factor registered so the output comes from a flop; lags the code by one clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            factor_ff <= rspc_pkg::FACTOR_HIGH;
        else
            factor_ff <= band_factor(reg_ff[4][2:0]); // RULE5
    end

    // Split time and reference halver
    assign synth_cfg.split_time_select      = reg_ff[16][rspc_pkg::SPLIT_BIT];  // RULE1
    assign synth_cfg.reference_halver       = reg_ff[15][rspc_pkg::REFERENCE_HALVER_BIT]; // RULE2
    // Oscillator enables share the reference setup register
    assign synth_cfg.low_oscillator_enable  = reg_ff[15][rspc_pkg::VCO_L_BIT];
    assign synth_cfg.high_oscillator_enable = reg_ff[15][rspc_pkg::VCO_H_BIT];

    // Pump code sits above the top divider bits
    assign synth_cfg.pump_current_code      = reg_ff[1][7:5]; // RULE4
    // Divider word spans four bytes; no atomic update across them
    assign synth_cfg.pll_divider_word       = {reg_ff[1][4:0], reg_ff[2], reg_ff[3], reg_ff[4][7:3]}; // RULE3
    // Band code shares the lowest divider register
    assign synth_cfg.band_divide_select     = reg_ff[4][2:0]; // RULE5

    // Channel step and the two separate IF settings
    assign synth_cfg.channel_step_value     = reg_ff[5]; // RULE6
    assign synth_cfg.analog_if_value        = reg_ff[0]; // RULE7
    assign synth_cfg.digital_if_value       = reg_ff[6]; // RULE7

    // Signed trim; the consumer sign-extends from bit 11
    assign synth_cfg.carrier_trim_value     = {reg_ff[7][3:0], reg_ff[8]}; // RULE8

    // Index 0 is slot four, index 4 is slot eight
    assign synth_cfg.power_levels           = {reg_ff[9][6:0], reg_ff[10][6:0], reg_ff[11][6:0],
                                               reg_ff[12][6:0], reg_ff[13][6:0]}; // RULE9
    // Final slot index in the low bits of its register
    assign synth_cfg.final_power_slot_index = reg_ff[14][2:0]; // RULE10

    // Band factor straight from its flop
    assign band_divide_factor = factor_ff;

    // Bus answer straight from its flops
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;

endmodule // rspc_regs

// File: verification/rspc_regs_chk.sv
`timescale 1ns/10ps
// Port-level checks of the register bank
module rspc_regs_chk #(
    parameter int ADDR_WIDTH = 10
) (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [ADDR_WIDTH-1:0]        paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [3:0]                   pstrb,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire rspc_pkg::rspc_synth_cfg_type synth_cfg,
    input wire logic [5:0]                   band_divide_factor
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Commit edge; a write without lane zero changes nothing
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
    // Commit to either carrier trim register
    logic trim_wr;
    assign trim_wr = wr_ok && (paddr == 10'h038 || paddr == 10'h03C);
    // Setup cycle, then first access cycle
    sequence s_acc;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_wr(logic [9:0] a);
        wr_ok && paddr == a;
    endsequence
    function automatic logic [5:0] fac(input logic [2:0] c);
        return c == 3'h1 ? 6'h06 : c == 3'h3 ? 6'h0C : c == 3'h4 ? 6'h10 : c == 3'h5 ? 6'h20 : 6'h00;
    endfunction
    a_ready_wait: assert property (s_acc |=> pready)
        else $error("no answer after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("answer too long");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    a_band_decode: assert property (band_divide_factor == fac($past(synth_cfg.band_divide_select)))
        else $error("band factor wrong");
    a_split_write: assert property (s_wr(10'h27C) |=> synth_cfg.split_time_select == $past(pwdata[7]))
        else $error("split select not written");
    a_reference_halver_write: assert property (s_wr(10'h278) |=> synth_cfg.reference_halver == $past(pwdata[7]))
        else $error("reference halver not written");
    a_divtop_write: assert property (s_wr(10'h020) |=>
        {synth_cfg.pump_current_code, synth_cfg.pll_divider_word[25:21]} == $past(pwdata[7:0]))
        else $error("divider top not written");
    a_digif_write: assert property (s_wr(10'h034) |=> synth_cfg.digital_if_value == $past(pwdata[7:0]))
        else $error("digital IF not written");
    a_slot_write: assert property (s_wr(10'h040) |=> synth_cfg.power_levels[4] == $past(pwdata[6:0]))
        else $error("slot level not written");
    a_trim_hold: assert property ($changed(synth_cfg.carrier_trim_value) |-> $past(trim_wr))
        else $error("trim changed without write");
endmodule // rspc_regs_chk

bind rspc_regs rspc_regs_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .synth_cfg(synth_cfg), .band_divide_factor(band_divide_factor));

// File: verification/tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the register bank
module tb_top;
    logic                         pclk    = 1'b0;
    logic                         presetn = 1'b0;
    logic                         psel    = 1'b0;
    logic                         penable = 1'b0;
    logic                         pwrite  = 1'b0;
    logic [9:0]                   paddr   = 10'h000;
    logic [31:0]                  pwdata  = 32'h0;
    logic [3:0]                   pstrb   = 4'h0;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    rspc_pkg::rspc_synth_cfg_type synth_cfg;
    logic [5:0]                   band_divide_factor;
    logic [16:0][7:0]             mdl     = rspc_pkg::REG_RST;
    logic [31:0]                  seed    = 32'h196BC2BF;
    int                           error_cnt = 0;
    int                           tests_run = 0;

    rspc_regs #(.ADDR_WIDTH(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .synth_cfg(synth_cfg), .band_divide_factor(band_divide_factor));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected consumer view built from the byte model
    function automatic rspc_pkg::rspc_synth_cfg_type exp_cfg();
        return {mdl[16][7], mdl[15][7], mdl[15][2], mdl[15][1], mdl[1], mdl[2], mdl[3], mdl[4], mdl[5], mdl[0],
            mdl[6], mdl[7][3:0], mdl[8], mdl[9][6:0], mdl[10][6:0], mdl[11][6:0], mdl[12][6:0], mdl[13][6:0],
            mdl[14][2:0]};
    endfunction
    function automatic logic [5:0] exp_fac(input logic [2:0] c);
        return c == 3'h1 ? 6'h06 : c == 3'h3 ? 6'h0C : c == 3'h4 ? 6'h10 : c == 3'h5 ? 6'h20 : 6'h00;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want)
        begin
            error_cnt++;
            $display("[ERR] %0t value %h expected %h", $time, got, want);
        end
    endtask
    task automatic chk_cfg(input rspc_pkg::rspc_synth_cfg_type got, input rspc_pkg::rspc_synth_cfg_type want);
        tests_run++;
        if (got !== want)
        begin
            error_cnt++;
            $display("[ERR] %0t settings %h expected %h", $time, got, want);
        end
    endtask
    // One APB transfer; bounded wait so a dead slave cannot hang the run
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Index 17 is misaligned, 18 and 19 unmapped
    task automatic access(input int i, input logic w, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic        er;
        logic        hit;
        hit = i < 17;
        xfer(w, hit ? {rspc_pkg::REG_OFS[i], 2'b00} : (i == 17 ? 10'h01E : 10'h054), d, s, rd, er);
        if (w && hit && s[0])
            mdl[i] = (mdl[i] & ~rspc_pkg::REG_MSK[i]) | (d[7:0] & rspc_pkg::REG_MSK[i]);
        chk({31'h0, er}, {31'h0, !hit});
        if (!w)
            chk(rd, hit ? {24'h0, mdl[i]} : 32'h0);
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        chk_cfg(synth_cfg, exp_cfg());
        chk({26'h0, band_divide_factor}, {26'h0, exp_fac(mdl[4][2:0])});
    endtask
    task automatic read_all();
        for (int i = 0; i < 20; i++)
            access(i, 1'b0, 32'h0, 4'h0);
        settle();
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset values, band codes, reserved bits, random traffic, reset in mid-run
    initial
    begin
        logic [31:0] r;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        read_all();
        for (int b = 0; b < 8; b++)
        begin
            r = next_rand();
            access(4, 1'b1, {r[31:3], b[2:0]}, 4'hF);
            settle();
        end
        for (int i = 0; i < 17; i++)
            access(i, 1'b1, 32'hFFFFFFFF, 4'h1);
        read_all();
        for (int k = 0; k < 150; k++)
        begin
            r = next_rand();
            access(int'(r % 20), r[31], next_rand(), r[12:9]);
            settle();
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        mdl = rspc_pkg::REG_RST;
        read_all();
        wrap_up();
    end

    // Watchdog, far beyond the roughly 1300 cycles the run needs
    initial
    begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end
endmodule // tb_top
